// >>> src/sfrs_space_stack.sv
// register space decoder, core registers and stack pointer
// Operation
// - stack pointer lives at register address 0x81 and places the stack.
// - stack pointer holds the address of the top entry; a pop steps it back to the entry below.
// - push increments the pointer, then writes at the new pointer value.
// - every reset loads the pointer with 0x07, first push lands at 0x08.
// - stack may sit anywhere in 256 bytes; pointer arithmetic is 8 bits.
// - direct accesses to 0x80 to 0xFF go to the register space.
// - registers at addresses ending 0x0 or 0x8 allow single-bit access.
// - all other register addresses are whole-byte only.
// - indirect byte accesses above 0x7F reach upper RAM, never registers.
`timescale 1ns/100ps
module sfrs_space_stack (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // core data access
    input wire sfrs_pkg::sfrs_req_t req_i,
    // core stack operations
    input wire logic push_i,
    input wire logic [7:0] push_data_i,
    input wire logic pop_i,
    // data RAM port
    output sfrs_pkg::sfrs_mem_t ram_o,
    input wire logic [7:0] ram_rdata_i,
    // peripheral register port
    output sfrs_pkg::sfrs_mem_t ext_o,
    input wire logic [7:0] ext_rdata_i,
    // read answer
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    // core register values
    output logic [7:0] stack_pointer_o,
    output logic [15:0] data_pointer_o,
    output logic [7:0] accumulator_o,
    output logic [7:0] multiply_divide_aux_o
);
    import sfrs_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] stack_pointer;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic [7:0] accumulator;
    logic [7:0] multiply_divide_aux;
    logic rd_pending;
    sfrs_src_t rd_src;
    logic [7:0] local_q;
    logic bit_q;
    logic [2:0] idx_q;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic stack_op;
    logic acc_ok;
    logic [7:0] byte_addr;
    logic [2:0] bit_idx;
    logic to_sfr;
    logic to_ram;
    logic occupied;
    logic is_local;
    logic [7:0] local_val;
    logic to_ext;
    logic local_we;
    logic [7:0] next_wval;
    logic [7:0] next_push_addr;
    logic [7:0] sel_byte;
    sfrs_src_t next_src;

    function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] i,
                                           input logic b);
        logic [7:0] r;
        r = v;
        r[i] = b;
        return r;
    endfunction : set_bit

    assign stack_op = push_i | pop_i;
    assign acc_ok = req_i.valid & ~stack_op;
    assign bit_idx = req_i.addr[2:0];
    assign byte_addr = !req_i.bit_op ? req_i.addr :
                       req_i.addr[SFRS_SPACE_BIT] ? {req_i.addr[7:3], 3'h0} :
                       {SFRS_BIT_RAM_BASE, req_i.addr[6:3]};
    assign to_sfr = acc_ok & (req_i.bit_op | ~req_i.indirect) & byte_addr[SFRS_SPACE_BIT];
    assign to_ram = acc_ok & ~to_sfr;
    assign occupied = SFRS_OCCUPIED[byte_addr[6:0]];

    always_comb begin
        is_local = 1'b1;
        local_val = 8'h00;
        unique case (byte_addr)
            SFRS_ADDR_STACK_POINTER: local_val = stack_pointer;
            SFRS_ADDR_DATA_POINTER_LOW: local_val = data_pointer_low;
            SFRS_ADDR_DATA_POINTER_HIGH: local_val = data_pointer_high;
            SFRS_ADDR_ACCUMULATOR: local_val = accumulator;
            SFRS_ADDR_MULTIPLY_DIVIDE_AUX: local_val = multiply_divide_aux;
            default: is_local = 1'b0;
        endcase
    end

    assign to_ext = to_sfr & occupied & ~is_local;
    assign local_we = to_sfr & is_local & req_i.write;
    assign next_wval = req_i.bit_op ? set_bit(local_val, bit_idx, req_i.wdata[0]) : req_i.wdata;
    assign next_push_addr = stack_pointer + SFRS_STACK_STEP;

    // ----------------------------------------------------------------
    // stack pointer
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stack_pointer <= SFRS_RST_STACK_POINTER;
        end else if (push_i) begin
            stack_pointer <= next_push_addr;
        end else if (pop_i) begin
            stack_pointer <= stack_pointer - SFRS_STACK_STEP;
        end else if (local_we && byte_addr == SFRS_ADDR_STACK_POINTER) begin
            stack_pointer <= next_wval;
        end
    end

    // ----------------------------------------------------------------
    // data registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_pointer_low <= SFRS_RST_DATA_REG;
            data_pointer_high <= SFRS_RST_DATA_REG;
            accumulator <= SFRS_RST_DATA_REG;
            multiply_divide_aux <= SFRS_RST_DATA_REG;
        end else if (local_we) begin
            if (byte_addr == SFRS_ADDR_DATA_POINTER_LOW) begin
                data_pointer_low <= next_wval;
            end
            if (byte_addr == SFRS_ADDR_DATA_POINTER_HIGH) begin
                data_pointer_high <= next_wval;
            end
            if (byte_addr == SFRS_ADDR_ACCUMULATOR) begin
                accumulator <= next_wval;
            end
            if (byte_addr == SFRS_ADDR_MULTIPLY_DIVIDE_AUX) begin
                multiply_divide_aux <= next_wval;
            end
        end
    end

    // ----------------------------------------------------------------
    // outgoing requests
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ram_o <= '0;
        end else if (push_i) begin
            ram_o <= '{valid: 1'b1, write: 1'b1, bit_op: 1'b0, bit_idx: 3'h0,
                       addr: next_push_addr, wdata: push_data_i};
        end else if (pop_i) begin
            ram_o <= '{valid: 1'b1, write: 1'b0, bit_op: 1'b0, bit_idx: 3'h0,
                       addr: stack_pointer, wdata: 8'h00};
        end else begin
            ram_o <= '{valid: to_ram, write: req_i.write, bit_op: req_i.bit_op,
                       bit_idx: bit_idx, addr: byte_addr,
                       wdata: req_i.bit_op ? {7'h00, req_i.wdata[0]} : req_i.wdata};
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_o <= '0;
        end else begin
            ext_o <= '{valid: to_ext, write: req_i.write, bit_op: req_i.bit_op,
                       bit_idx: bit_idx, addr: byte_addr,
                       wdata: req_i.bit_op ? {7'h00, req_i.wdata[0]} : req_i.wdata};
        end
    end

    // ----------------------------------------------------------------
    // read answer
    // ----------------------------------------------------------------
    always_comb begin
        next_src = SFRS_SRC_ZERO;
        if (stack_op || to_ram) begin
            next_src = SFRS_SRC_RAM;
        end else if (to_ext) begin
            next_src = SFRS_SRC_EXT;
        end else if (to_sfr && is_local) begin
            next_src = SFRS_SRC_LOCAL;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_pending <= 1'b0;
            rd_src <= SFRS_SRC_ZERO;
            local_q <= 8'h00;
            bit_q <= 1'b0;
            idx_q <= 3'h0;
        end else begin
            rd_pending <= (pop_i & ~push_i) | (acc_ok & ~req_i.write);
            rd_src <= next_src;
            local_q <= local_val;
            bit_q <= ~stack_op & req_i.bit_op;
            idx_q <= bit_idx;
        end
    end

    always_comb begin
        unique case (rd_src)
            SFRS_SRC_ZERO: sel_byte = 8'h00;
            SFRS_SRC_LOCAL: sel_byte = local_q;
            SFRS_SRC_RAM: sel_byte = ram_rdata_i;
            SFRS_SRC_EXT: sel_byte = ext_rdata_i;
            default: sel_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 8'h00;
        end else begin
            rsp_valid_o <= rd_pending;
            rsp_data_o <= bit_q ? {7'h00, sel_byte[idx_q]} : sel_byte;
        end
    end

    assign stack_pointer_o = stack_pointer;
    assign data_pointer_o = {data_pointer_high, data_pointer_low};
    assign accumulator_o = accumulator;
    assign multiply_divide_aux_o = multiply_divide_aux;

endmodule : sfrs_space_stack

// >>> src/sfrs_pkg.sv
// constants, carriers and types of the register space decoder and stack pointer
package sfrs_pkg;

    // ----------------------------------------------------------------
    // register space addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] SFRS_ADDR_STACK_POINTER = 8'h81;
    localparam logic [7:0] SFRS_ADDR_DATA_POINTER_LOW = 8'h82;
    localparam logic [7:0] SFRS_ADDR_DATA_POINTER_HIGH = 8'h83;
    localparam logic [7:0] SFRS_ADDR_ACCUMULATOR = 8'hE0;
    localparam logic [7:0] SFRS_ADDR_MULTIPLY_DIVIDE_AUX = 8'hF0;

    // upper half of the data space, direct mode, is the register space
    localparam int SFRS_SPACE_BIT = 7;
    // bit addresses below the register space map onto bytes 0x20 to 0x2F
    localparam logic [3:0] SFRS_BIT_RAM_BASE = 4'h2;

    // ----------------------------------------------------------------
    // values after reset and the stack step
    // ----------------------------------------------------------------
    localparam logic [7:0] SFRS_RST_STACK_POINTER = 8'h07;
    localparam logic [7:0] SFRS_RST_DATA_REG = 8'h00;
    localparam logic [7:0] SFRS_STACK_STEP = 8'h01;

    // occupied register-space locations, bit n = address 0x80 + n
    localparam logic [127:0] SFRS_OCCUPIED = {
        8'hFF, 8'h5F, 8'hFF, 8'h57, 8'h7F, 8'h73, 8'h3D, 8'h7F,
        8'h7D, 8'hCF, 8'h07, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h8F
    };

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic indirect;
        logic bit_op;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfrs_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic bit_op;
        logic [2:0] bit_idx;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfrs_mem_t;

    typedef enum logic [3:0] {
        SFRS_SRC_ZERO = 4'b0001,
        SFRS_SRC_LOCAL = 4'b0010,
        SFRS_SRC_RAM = 4'b0100,
        SFRS_SRC_EXT = 4'b1000
    } sfrs_src_t;

endpackage : sfrs_pkg

// >>> test/sfrs_checker.sv
// assertions on the ports of the register space decoder
`timescale 1ns/100ps
module sfrs_checker (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire sfrs_pkg::sfrs_req_t req_i,
    input wire logic push_i,
    input wire logic [7:0] push_data_i,
    input wire logic pop_i,
    input wire sfrs_pkg::sfrs_mem_t ram_o,
    input wire logic [7:0] ram_rdata_i,
    input wire sfrs_pkg::sfrs_mem_t ext_o,
    input wire logic [7:0] ext_rdata_i,
    input wire logic rsp_valid_o,
    input wire logic [7:0] rsp_data_o,
    input wire logic [7:0] stack_pointer_o,
    input wire logic [15:0] data_pointer_o,
    input wire logic [7:0] accumulator_o,
    input wire logic [7:0] multiply_divide_aux_o
);
    import sfrs_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence take_s;
        req_i.valid && !push_i && !pop_i;
    endsequence
    sequence rd_s(a);
        take_s ##0 !req_i.write && !req_i.indirect && !req_i.bit_op && req_i.addr == a;
    endsequence
    AST_PUSH_STEP: assert property (push_i |=>
        stack_pointer_o == 8'($past(stack_pointer_o) + 8'h01)) else $error("pointer step");
    AST_PUSH_PLACE: assert property (push_i |=> ram_o.valid && ram_o.write &&
        ram_o.addr == stack_pointer_o && ram_o.wdata == $past(push_data_i)) else $error("push");
    AST_RESET_LOAD: assert property (disable iff (1'b0)
        !nrst_i |-> stack_pointer_o == SFRS_RST_STACK_POINTER) else $error("reset load");
    AST_PTR_READ: assert property (rd_s(SFRS_ADDR_STACK_POINTER) ##1
        !push_i && !pop_i && !req_i.write |=> rsp_valid_o && rsp_data_o == stack_pointer_o)
        else $error("pointer read");
    AST_DIRECT_HIGH: assert property (take_s ##0 !req_i.indirect &&
        !req_i.bit_op && req_i.addr[7] |=> !ram_o.valid) else $error("direct high");
    AST_INDIRECT_RAM: assert property (take_s ##0 req_i.indirect && !req_i.bit_op |=>
        ram_o.valid && ram_o.addr == $past(req_i.addr) && !ext_o.valid) else $error("indirect");
    AST_RESERVED_ZERO: assert property (rd_s(8'h84) |=>
        !ram_o.valid && !ext_o.valid ##1 rsp_valid_o && rsp_data_o == 8'h00)
        else $error("reserved");
    AST_BIT_TARGET: assert property (take_s ##0 req_i.bit_op && req_i.addr[7] |=>
        !ext_o.valid || ext_o.bit_op && ext_o.addr[2:0] == 3'b000 &&
        {ext_o.addr[7:3], ext_o.bit_idx} == $past(req_i.addr)) else $error("bit target");
endmodule : sfrs_checker
bind sfrs_space_stack sfrs_checker i_chk (.clock_i, .nrst_i, .req_i, .push_i, .push_data_i,
    .pop_i, .ram_o, .ram_rdata_i, .ext_o, .ext_rdata_i, .rsp_valid_o, .rsp_data_o,
    .stack_pointer_o, .data_pointer_o, .accumulator_o, .multiply_divide_aux_o);

// >>> test/sfrs_mem_model.sv
// data RAM and peripheral registers around the decoder
`timescale 1ns/100ps
module sfrs_mem_model (
    // clock
    input wire logic clock_i,
    // requests
    input wire sfrs_pkg::sfrs_mem_t ram_i,
    input wire sfrs_pkg::sfrs_mem_t ext_i,
    // read data
    output logic [7:0] ram_rdata_o,
    output logic [7:0] ext_rdata_o
);
    import sfrs_pkg::*;
    logic [7:0] ram [256] = '{default: 8'h00};
    logic [7:0] per [256] = '{default: 8'h00};
    // idle lines show the inverse, never a stale value
    assign ram_rdata_o = ram_i.valid ? ram[ram_i.addr] : ~ram[ram_i.addr];
    assign ext_rdata_o = ext_i.valid ? per[ext_i.addr] : ~per[ext_i.addr];
    function automatic logic [7:0] merge(input logic [7:0] old, input sfrs_mem_t m);
        logic [7:0] v;
        v = m.bit_op ? old : m.wdata;
        if (m.bit_op) begin
            v[m.bit_idx] = m.wdata[0];
        end
        return v;
    endfunction : merge
    always @(posedge clock_i) begin
        if (ram_i.valid && ram_i.write) begin
            ram[ram_i.addr] <= merge(ram[ram_i.addr], ram_i);
        end
        if (ext_i.valid && ext_i.write) begin
            per[ext_i.addr] <= merge(per[ext_i.addr], ext_i);
        end
    end
endmodule : sfrs_mem_model

// >>> test/tb_sfr_space_and_stack_pointer.sv
// self-checking bench of the register space decoder and stack pointer
`timescale 1ns/100ps
module tb_sfr_space_and_stack_pointer;
    import sfrs_pkg::*;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b1;
    sfrs_req_t req_i = '0;
    logic push_i = 1'b0;
    logic [7:0] push_data_i = 8'h00;
    logic pop_i = 1'b0;
    sfrs_mem_t ram_o;
    sfrs_mem_t ext_o;
    logic [7:0] ram_rdata_i;
    logic [7:0] ext_rdata_i;
    logic rsp_valid_o;
    logic [7:0] rsp_data_o;
    logic [7:0] stack_pointer_o;
    logic [15:0] data_pointer_o;
    logic [7:0] accumulator_o;
    logic [7:0] multiply_divide_aux_o;
    int err_count = 0;
    int checks = 0;
    always #20 clock_i = ~clock_i;
    sfrs_space_stack i_dut (.clock_i, .nrst_i, .req_i, .push_i, .push_data_i, .pop_i, .ram_o,
        .ram_rdata_i, .ext_o, .ext_rdata_i, .rsp_valid_o, .rsp_data_o, .stack_pointer_o,
        .data_pointer_o, .accumulator_o, .multiply_divide_aux_o);
    sfrs_mem_model i_mem (.clock_i, .ram_i(ram_o), .ext_i(ext_o), .ram_rdata_o(ram_rdata_i),
        .ext_rdata_o(ext_rdata_i));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // one access; a read compares its answer with e
    task automatic acc(input logic w, input logic ind, input logic b, input logic [7:0] a,
        input logic [7:0] d, input logic [7:0] e);
        @(negedge clock_i);
        req_i = '{valid: 1'b1, write: w, indirect: ind, bit_op: b, addr: a, wdata: d};
        @(negedge clock_i);
        req_i = '0;
        @(negedge clock_i);
        chk("answer", 16'(rsp_valid_o), 16'(!w));
        if (!w) begin
            chk("read", 16'(rsp_data_o), 16'(e));
        end
    endtask : acc
    task automatic push(input logic [7:0] d, input logic [7:0] e);
        @(negedge clock_i);
        push_i = 1'b1;
        push_data_i = d;
        @(negedge clock_i);
        push_i = 1'b0;
        chk("pointer", 16'(stack_pointer_o), 16'(e));
        chk("push", 16'({ram_o.valid, ram_o.write, ram_o.addr}), 16'({2'b11, e}));
        chk("push data", 16'(ram_o.wdata), 16'(d));
    endtask : push
    // one pop; p is the pointer after it, e the value read back
    task automatic pop(input logic [7:0] p, input logic [7:0] e);
        @(negedge clock_i);
        pop_i = 1'b1;
        @(negedge clock_i);
        pop_i = 1'b0;
        chk("pop pointer", 16'(stack_pointer_o), 16'(p));
        chk("pop read", 16'({ram_o.valid, ram_o.write, ram_o.addr}), 16'({2'b10, 8'(p + 8'h01)}));
        @(negedge clock_i);
        chk("pop answer", 16'({rsp_valid_o, rsp_data_o}), 16'({1'b1, e}));
    endtask : pop
    task automatic t_reset;
        @(negedge clock_i);
        nrst_i = 1'b0;
        repeat (2) @(negedge clock_i);
        nrst_i = 1'b1;
        chk("reset pointer", 16'(stack_pointer_o), 16'h0007);
        chk("reset dptr", data_pointer_o, 16'h0000);
    endtask : t_reset
    task automatic t_stack;
        push(8'hA5, 8'h08);
        acc(1'b0, 1'b0, 1'b0, 8'h08, 8'h00, 8'hA5);
        // stack moved to 0xFE so the next two pushes wrap to 0x00
        acc(1'b1, 1'b0, 1'b0, SFRS_ADDR_STACK_POINTER, 8'hFE, 8'h00);
        push(8'h11, 8'hFF);
        push(8'h22, 8'h00);
        acc(1'b0, 1'b0, 1'b0, SFRS_ADDR_STACK_POINTER, 8'h00, 8'h00);
        acc(1'b0, 1'b1, 1'b0, 8'hFF, 8'h00, 8'h11);
        pop(8'hFF, 8'h22);
        pop(8'hFE, 8'h11);
    endtask : t_stack
    task automatic t_space;
        acc(1'b1, 1'b0, 1'b0, SFRS_ADDR_DATA_POINTER_LOW, 8'h5A, 8'h00);
        acc(1'b1, 1'b1, 1'b0, 8'h82, 8'hC3, 8'h00);
        acc(1'b0, 1'b0, 1'b0, 8'h82, 8'h00, 8'h5A);
        acc(1'b0, 1'b1, 1'b0, 8'h82, 8'h00, 8'hC3);
        acc(1'b1, 1'b0, 1'b0, SFRS_ADDR_MULTIPLY_DIVIDE_AUX, 8'h3C, 8'h00);
        chk("dptr", data_pointer_o, 16'h005A);
        chk("aux", 16'(multiply_divide_aux_o), 16'h003C);
    endtask : t_space
    task automatic t_bits;
        acc(1'b1, 1'b0, 1'b1, 8'hE3, 8'h01, 8'h00);
        chk("acc bit", 16'(accumulator_o), 16'h0008);
        acc(1'b0, 1'b0, 1'b1, 8'hE3, 8'h00, 8'h01);
        acc(1'b1, 1'b0, 1'b1, 8'h8B, 8'h01, 8'h00);
        acc(1'b0, 1'b0, 1'b0, 8'h88, 8'h00, 8'h08);
        acc(1'b1, 1'b0, 1'b1, 8'h13, 8'h01, 8'h00);
        acc(1'b0, 1'b0, 1'b0, 8'h22, 8'h00, 8'h08);
    endtask : t_bits
    task automatic t_reserved;
        acc(1'b1, 1'b0, 1'b0, 8'h84, 8'hFF, 8'h00);
        acc(1'b0, 1'b0, 1'b0, 8'h84, 8'h00, 8'h00);
    endtask : t_reserved
    initial begin
        t_reset();
        t_stack();
        t_space();
        t_bits();
        t_reserved();
        t_reset();
        push(8'h5C, 8'h08);
        end_sim();
    end
    initial begin
        #(40 * 5000);
        err_count++;
        end_sim();
    end
endmodule : tb_sfr_space_and_stack_pointer
